// file: verilog/beu_branch_unit.sv
// Branch execution unit: decode, condition test, target, link and timing
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Register-offset conditional: taken adds offset register to pc, else pc plus 4.
// - Immediate conditional: taken adds sign-extended 16-bit constant to pc.
// - Less-than forms branch only when compared register is below zero.
// - Not-equal forms branch only when compared register is nonzero.
// - Delayed immediate less-or-equal branches when compared register is at most zero.
// - Taken with delay flag: the next sequential instruction still completes.
// - Taken without delay flag: next sequential instruction is killed.
// - Conditional: 1 cycle not taken, 2 taken delayed, 3 taken undelayed.
// - Unconditional: 2 cycles delayed, 3 cycles undelayed.
// - Conditional fields: delay bit 6, compared register bit 11, offset bit 16.
// - Linking unconditional branch writes current pc into destination register.
// - Register form: absolute loads offset register, relative adds it to pc.
// - Immediate form: absolute uses constant, relative adds constant to pc.
// - Unconditional immediate constant is sign-extended to 32 bits.
// - Jump fields: destination bits 6-10, flags from 11, offset register at 16.
// - Link, absolute and delay flags are taken from their encoding bits.
// - Register-form link without delay is offered only when absolute, as the break encoding.
// - Immediate-form link without delay is not offered.
// - Break stores pc, jumps absolute to offset register, sets break flag.
// - Delayed not-equal immediate uses delay flag and constant in bits 16-31.
module beu_branch_unit (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // Instruction issue
  input  wire logic        i_instr_valid,
  input  wire logic [31:0] i_instr,
  input  wire logic [31:0] i_pc,
  output logic             o_ready,
  // Register file read
  output logic [4:0]       o_compare_source_reg,
  output logic [4:0]       o_offset_source_reg,
  input  wire logic [31:0] i_compare_data,
  input  wire logic [31:0] i_offset_data,
  // Program counter redirect
  output logic             o_pc_load,
  output logic [31:0]      o_pc_target,
  output logic             o_taken,
  output logic             o_flush_next,
  output logic             o_delay_slot,
  output logic             o_illegal,
  output logic             o_done,
  // Link write
  output logic             o_link_we,
  output logic [4:0]       o_link_sel,
  output logic [31:0]      o_link_data,
  // Machine state word break flag
  input  wire logic        i_break_clear,
  output logic             o_break_in_progress_flag
);

  typedef enum logic [1:0] {
    BEU_IDLE = 2'b01,
    BEU_HOLD = 2'b10
  } beu_state_t;

  beu_state_t state;
  beu_state_t next_state;

  // Decoder outputs
  wire logic        dec_cond;
  wire logic        dec_jump;
  wire logic        dec_imm;
  wire logic        dec_break;
  wire logic        dec_illegal;
  wire logic        dec_delay;
  wire logic        dec_abs;
  wire logic        dec_link;
  wire logic [2:0]  dec_code;
  wire logic [4:0]  dec_cmp_sel;
  wire logic [4:0]  dec_ofs_sel;
  wire logic [4:0]  dec_dest_sel;
  wire logic [31:0] dec_imm_sext;

  beu_decode u_decode (
    .i_instr    (i_instr),
    .o_is_cond  (dec_cond),
    .o_is_jump  (dec_jump),
    .o_is_imm   (dec_imm),
    .o_is_break (dec_break),
    .o_illegal  (dec_illegal),
    .o_delay    (dec_delay),
    .o_absolute (dec_abs),
    .o_link     (dec_link),
    .o_cond     (dec_code),
    .o_cmp_sel  (dec_cmp_sel),
    .o_ofs_sel  (dec_ofs_sel),
    .o_dest_sel (dec_dest_sel),
    .o_imm_sext (dec_imm_sext)
  );

  // Signed compare against zero, shared by every conditional form
  function automatic logic cond_holds(input logic [2:0] code, input logic [31:0] value);
    logic neg;
    logic zero;
    neg  = $signed(value) < 0;
    zero = (value == beu_pkg::RST_DATA);
    if (code == beu_pkg::COND_LT) begin
      cond_holds = neg;
    end else if (code == beu_pkg::COND_NE) begin
      cond_holds = !zero;
    end else if (code == beu_pkg::COND_LE) begin
      cond_holds = neg || zero;
    end else begin
      cond_holds = 1'b0;
    end
  endfunction : cond_holds

  // Issue and branch resolution
  wire logic        accept;
  wire logic        take;
  wire logic [31:0] offset;
  wire logic [31:0] target;
  wire logic [1:0]  latency;

  assign o_compare_source_reg = dec_cmp_sel;
  assign o_offset_source_reg  = dec_ofs_sel;

  assign o_ready = (state == BEU_IDLE);
  assign accept  = i_instr_valid && o_ready;

  // Unconditional forms and break always redirect
  assign take = dec_jump || (dec_cond && cond_holds(dec_code, i_compare_data));

  assign offset = dec_imm ? dec_imm_sext : i_offset_data;

  // Absolute loads the operand, relative adds it, not taken steps by one word
  assign target = !take  ? i_pc + beu_pkg::PC_STEP
                : dec_abs ? offset
                : i_pc + offset;

  // Break has its delay bit clear so it costs the full three cycles
  assign latency = !take    ? beu_pkg::LAT_SKIP
                 : dec_delay ? beu_pkg::LAT_DELAY
                 : beu_pkg::LAT_FLUSH;

  // Busy counter keeps o_ready low for the remaining cycles
  logic [1:0] busy_cnt;
  logic [1:0] next_busy_cnt;

  assign next_busy_cnt = accept ? 2'(latency - 2'h1)
                       : (busy_cnt != beu_pkg::RST_CNT) ? 2'(busy_cnt - 2'h1)
                       : busy_cnt;

  always_comb begin
    next_state = state;
    case (state)
      BEU_IDLE: begin
        if (accept && (latency != beu_pkg::LAT_SKIP)) begin
          next_state = BEU_HOLD;
        end
      end
      BEU_HOLD: begin
        if (busy_cnt == 2'h1) begin
          next_state = BEU_IDLE;
        end
      end
      default: begin
        next_state = BEU_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state    <= BEU_IDLE;
      busy_cnt <= beu_pkg::RST_CNT;
    end else begin
      state    <= next_state;
      busy_cnt <= next_busy_cnt;
    end
  end

  // Done marks the last cycle of the instruction's latency
  wire logic next_done;
  assign next_done = (accept && (latency == beu_pkg::LAT_SKIP))
                     || ((state == BEU_HOLD) && (busy_cnt == 2'h1));

  // Redirect outputs are registered one cycle after issue
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pc_load    <= 1'b0;
      o_pc_target  <= beu_pkg::RST_DATA;
      o_taken      <= 1'b0;
      o_flush_next <= 1'b0;
      o_delay_slot <= 1'b0;
      o_illegal    <= 1'b0;
      o_done       <= 1'b0;
    end else begin
      o_pc_load    <= accept;
      o_taken      <= accept && take;
      o_flush_next <= accept && take && !dec_delay;
      o_delay_slot <= accept && take && dec_delay;
      o_illegal    <= accept && dec_illegal;
      o_done       <= next_done;
      if (accept) begin
        o_pc_target <= target;
      end
    end
  end

  // Link write carries the pc of the branch itself
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_link_we   <= 1'b0;
      o_link_sel  <= beu_pkg::RST_SEL;
      o_link_data <= beu_pkg::RST_DATA;
    end else begin
      o_link_we <= accept && dec_jump && dec_link;
      if (accept && dec_jump && dec_link) begin
        o_link_sel  <= dec_dest_sel;
        o_link_data <= i_pc;
      end
    end
  end

  // Break flag: a break issued with a clear in the same cycle stays set
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_break_in_progress_flag <= 1'b0;
    end else if (accept && dec_break) begin
      o_break_in_progress_flag <= 1'b1;
    end else if (i_break_clear) begin
      o_break_in_progress_flag <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  skip_one_cycle_a: assert property (
    accept && !take |=> o_ready && o_done)
    else $error("Untaken branch did not finish in one cycle");

  delayed_two_cycle_a: assert property (
    accept && take && dec_delay |=> !o_ready && !o_done ##1 o_ready && o_done)
    else $error("Delayed taken branch did not take two cycles");

  undelayed_three_a: assert property (
    accept && take && !dec_delay |=> !o_ready [*2] ##1 o_ready)
    else $error("Undelayed taken branch did not take three cycles");

  step_target_a: assert property (
    accept && !take |=> o_pc_target == $past(i_pc) + beu_pkg::PC_STEP)
    else $error("Untaken branch target is not pc plus four");

  less_than_a: assert property (
    accept && dec_cond && (dec_code == beu_pkg::COND_LT)
    |=> o_taken == $past(i_compare_data[31]))
    else $error("Less-than decision does not follow the sign");

  not_equal_a: assert property (
    accept && dec_cond && (dec_code == beu_pkg::COND_NE)
    |=> o_taken == ($past(i_compare_data) != beu_pkg::RST_DATA))
    else $error("Not-equal decision wrong");

  imm_rel_target_a: assert property (
    accept && dec_cond && dec_imm && take
    |=> o_pc_target == $past(i_pc) + $past(dec_imm_sext))
    else $error("Immediate branch target wrong");

  reg_abs_target_a: assert property (
    accept && dec_jump && !dec_imm && dec_abs
    |=> o_pc_load && o_pc_target == $past(i_offset_data))
    else $error("Absolute register branch target wrong");

  link_value_a: assert property (
    accept && dec_jump && dec_link
    |=> o_link_we && o_link_data == $past(i_pc) && o_link_sel == $past(dec_dest_sel))
    else $error("Link write missing or wrong");

  flush_slot_a: assert property (
    accept && take && !dec_delay |=> o_flush_next && !o_delay_slot)
    else $error("Undelayed taken branch did not flush");

  delay_slot_a: assert property (
    accept && take && dec_delay |=> o_delay_slot && !o_flush_next)
    else $error("Delayed taken branch flushed its slot");

  break_flag_a: assert property (
    accept && dec_break |=> o_break_in_progress_flag && o_link_we
    && o_pc_target == $past(i_offset_data))
    else $error("Break did not link, jump and set its flag");

  no_link_nodelay_a: assert property (
    o_link_we |-> $past(dec_delay) || $past(dec_break))
    else $error("Link written without delay slot");

  reg_rel_target_a: assert property (
    accept && dec_cond && !dec_imm && take
    |=> o_pc_target == $past(i_pc) + $past(i_offset_data))
    else $error("Register conditional target is not pc plus offset");

  less_equal_a: assert property (
    accept && dec_cond && (dec_code == beu_pkg::COND_LE)
    |=> o_taken == ($past(i_compare_data[31]) || ($past(i_compare_data) == 32'h0000_0000)))
    else $error("Less-or-equal decision wrong");

  jump_rel_target_a: assert property (
    accept && dec_jump && !dec_imm && !dec_abs
    |=> o_pc_target == $past(i_pc) + $past(i_offset_data))
    else $error("Relative register jump target wrong");

  imm_rel_jump_a: assert property (
    accept && dec_jump && dec_imm && !dec_abs
    |=> o_pc_target == $past(i_pc) + $past(dec_imm_sext))
    else $error("Relative immediate jump target wrong");

  imm_abs_target_a: assert property (
    accept && dec_jump && dec_imm && dec_abs |=> o_pc_target == $past(dec_imm_sext))
    else $error("Absolute immediate jump target wrong");

  // Checked against the raw word so a swapped field in the decoder shows up
  sign_extend_a: assert property (
    dec_imm_sext == {{16{i_instr[15]}}, i_instr[15:0]})
    else $error("Immediate constant not sign-extended");

  field_select_a: assert property (
    (o_compare_source_reg == i_instr[20:16]) && (o_offset_source_reg == i_instr[15:11]))
    else $error("Register select fields wrong");

  cond_delay_bit_a: assert property (
    dec_cond |-> (dec_delay == i_instr[25]) && !dec_abs && !dec_link)
    else $error("Conditional delay flag taken from wrong bit");

  jump_flags_a: assert property (
    dec_jump |-> (dec_delay == i_instr[20]) && (dec_abs == i_instr[19])
    && (dec_link == i_instr[18]))
    else $error("Jump flags taken from wrong bits");

  dest_field_a: assert property (
    accept && dec_jump && dec_link |=> o_link_sel == $past(i_instr[25:21]))
    else $error("Link destination field wrong");

  illegal_quiet_a: assert property (
    accept && dec_illegal |=> o_illegal && !o_taken && !o_link_we && o_done
    && (o_pc_target == $past(i_pc) + beu_pkg::PC_STEP))
    else $error("Forbidden encoding had an effect");

  break_clear_a: assert property (
    i_break_clear && !(accept && dec_break) |=> !o_break_in_progress_flag)
    else $error("Break flag did not clear");

endmodule : beu_branch_unit
`default_nettype wire

// file: verilog/beu_pkg.sv
// Shared constants for the branch execution unit
package beu_pkg;

  // Data path widths
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned REG_W   = 5;
  localparam int unsigned IMM_W   = 16;
  localparam int unsigned COND_W  = 3;
  localparam int unsigned LAT_W   = 2;

  // Primary opcode, instruction bits [31:26]
  localparam logic [5:0] OPC_COND_REG   = 6'h27;
  localparam logic [5:0] OPC_COND_IMM   = 6'h2f;
  localparam logic [5:0] OPC_JUMP_REG   = 6'h26;
  localparam logic [5:0] OPC_JUMP_IMM   = 6'h2e;

  // Field positions as instruction vector indices (field bit 0 is the MSB)
  localparam int unsigned POS_OPC_LSB    = 26;
  localparam int unsigned POS_COND_DELAY = 25;
  localparam int unsigned POS_COND_SPARE = 24;
  localparam int unsigned POS_COND_LSB   = 21;
  localparam int unsigned POS_CMP_LSB    = 16;
  localparam int unsigned POS_OFS_LSB    = 11;
  localparam int unsigned POS_DEST_LSB   = 21;
  localparam int unsigned POS_JMP_DELAY  = 20;
  localparam int unsigned POS_JMP_ABS    = 19;
  localparam int unsigned POS_JMP_LINK   = 18;
  localparam int unsigned POS_IMM_LSB    = 0;

  // Condition codes
  localparam logic [COND_W-1:0] COND_NE = 3'h1;
  localparam logic [COND_W-1:0] COND_LT = 3'h2;
  localparam logic [COND_W-1:0] COND_LE = 3'h3;

  // Sequential step and latencies in cycles
  localparam logic [DATA_W-1:0] PC_STEP   = 32'h0000_0004;
  localparam logic [LAT_W-1:0]  LAT_SKIP  = 2'h1;
  localparam logic [LAT_W-1:0]  LAT_DELAY = 2'h2;
  localparam logic [LAT_W-1:0]  LAT_FLUSH = 2'h3;

  // Values after reset
  localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;
  localparam logic [REG_W-1:0]  RST_SEL  = 5'h00;
  localparam logic [LAT_W-1:0]  RST_CNT  = 2'h0;

endpackage : beu_pkg

// file: verilog/beu_decode.sv
// Instruction field decoder for the branch execution unit
`timescale 1ns/1ps
`default_nettype none
module beu_decode (
  // Instruction word
  input  wire logic [31:0] i_instr,
  // Decoded class
  output logic             o_is_cond,
  output logic             o_is_jump,
  output logic             o_is_imm,
  output logic             o_is_break,
  output logic             o_illegal,
  // Decoded flags
  output logic             o_delay,
  output logic             o_absolute,
  output logic             o_link,
  output logic [2:0]       o_cond,
  // Register selects and immediate
  output logic [4:0]       o_cmp_sel,
  output logic [4:0]       o_ofs_sel,
  output logic [4:0]       o_dest_sel,
  output logic [31:0]      o_imm_sext
);

  wire logic [5:0]  opc;
  wire logic        cond_op;
  wire logic        jump_op;
  wire logic        cond_ok;
  wire logic        link_nodelay;
  wire logic [15:0] imm;

  assign opc     = i_instr[beu_pkg::POS_OPC_LSB +: 6];
  assign cond_op = (opc == beu_pkg::OPC_COND_REG) || (opc == beu_pkg::OPC_COND_IMM);
  assign jump_op = (opc == beu_pkg::OPC_JUMP_REG) || (opc == beu_pkg::OPC_JUMP_IMM);
  assign o_is_imm = (opc == beu_pkg::OPC_COND_IMM) || (opc == beu_pkg::OPC_JUMP_IMM);

  assign o_cond   = i_instr[beu_pkg::POS_COND_LSB +: 3];
  // Only the not-equal and less-than forms, plus the immediate less-or-equal
  assign cond_ok  = !i_instr[beu_pkg::POS_COND_SPARE]
                    && ((o_cond == beu_pkg::COND_NE) || (o_cond == beu_pkg::COND_LT)
                        || ((o_cond == beu_pkg::COND_LE) && o_is_imm));

  // Flag positions differ between the two families
  assign o_delay    = cond_op ? i_instr[beu_pkg::POS_COND_DELAY]
                              : i_instr[beu_pkg::POS_JMP_DELAY];
  assign o_absolute = jump_op && i_instr[beu_pkg::POS_JMP_ABS];
  assign o_link     = jump_op && i_instr[beu_pkg::POS_JMP_LINK];

  // Register form with link and absolute but no delay is the break encoding
  assign o_is_break = (opc == beu_pkg::OPC_JUMP_REG) && o_link && o_absolute
                      && !o_delay;
  assign link_nodelay = jump_op && o_link && !o_delay && !o_is_break;

  assign o_is_cond = cond_op && cond_ok;
  assign o_is_jump = jump_op && !link_nodelay;
  assign o_illegal = (cond_op && !cond_ok) || link_nodelay;

  assign o_cmp_sel  = i_instr[beu_pkg::POS_CMP_LSB +: 5];
  assign o_ofs_sel  = i_instr[beu_pkg::POS_OFS_LSB +: 5];
  assign o_dest_sel = i_instr[beu_pkg::POS_DEST_LSB +: 5];

  assign imm        = i_instr[beu_pkg::POS_IMM_LSB +: 16];
  assign o_imm_sext = {{16{imm[15]}}, imm};

endmodule : beu_decode
`default_nettype wire

// file: tb/beu_tb.sv
// Self-checking bench for the branch execution unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [31:0] ins;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] tgt;
    logic [5:0]  f;
    logic [1:0]  lat;
  } beu_row_t;

  logic        i_clock = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_instr_valid = 1'b0;
  logic [31:0] i_instr = 32'h0000_0000;
  logic [31:0] i_pc = 32'h0000_0000;
  logic [31:0] i_compare_data = 32'h0000_0000;
  logic [31:0] i_offset_data = 32'h0000_0000;
  logic        i_break_clear = 1'b0;
  logic        o_ready, o_pc_load, o_taken, o_flush_next, o_delay_slot, o_illegal, o_done;
  logic        o_link_we, o_break_in_progress_flag;
  logic [4:0]  o_compare_source_reg, o_offset_source_reg, o_link_sel;
  logic [31:0] o_pc_target, o_link_data;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cycles = 0;
  beu_row_t    rows [20];
  // Register-form low half: offset register 7 in bits 15:11
  localparam logic [15:0] R = 16'h3800;

  beu_branch_unit DUT (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_pc(i_pc), .o_ready(o_ready),
    .o_compare_source_reg(o_compare_source_reg), .o_offset_source_reg(o_offset_source_reg),
    .i_compare_data(i_compare_data), .i_offset_data(i_offset_data),
    .o_pc_load(o_pc_load), .o_pc_target(o_pc_target), .o_taken(o_taken),
    .o_flush_next(o_flush_next), .o_delay_slot(o_delay_slot), .o_illegal(o_illegal),
    .o_done(o_done), .o_link_we(o_link_we), .o_link_sel(o_link_sel),
    .o_link_data(o_link_data), .i_break_clear(i_break_clear),
    .o_break_in_progress_flag(o_break_in_progress_flag)
  );

  always #25 i_clock = ~i_clock;

  // Hang guard: the whole run needs under a hundred cycles
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      test_done();
    end
  end

  function automatic logic [31:0] mc(bit im, bit d, logic [2:0] c, logic [15:0] lo);
    mc = {im ? beu_pkg::OPC_COND_IMM : beu_pkg::OPC_COND_REG, d, 1'b0, c, 5'h03, lo};
  endfunction : mc

  function automatic logic [31:0] mj(bit im, bit d, bit ab, bit l, logic [15:0] lo);
    mj = {im ? beu_pkg::OPC_JUMP_IMM : beu_pkg::OPC_JUMP_REG, 5'h0f, d, ab, l, 2'b00, lo};
  endfunction : mj

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    if (n_fail == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  task automatic drv(input logic [31:0] ins, a, b, pc);
    i_instr_valid = 1'b1;
    i_instr = ins;
    i_compare_data = a;
    i_offset_data = b;
    i_pc = pc;
  endtask : drv

  // Issue one row and follow it until completion
  task automatic run_row(input beu_row_t r);
    int n;
    @(negedge i_clock);
    drv(r.ins, r.a, r.b, 32'h0000_1000);
    #1;
    if (r.ins[26]) chk(o_compare_source_reg, 5'h03, "cmp sel");
    if (!r.ins[29]) chk(o_offset_source_reg, 5'h07, "ofs sel");
    @(posedge i_clock);
    @(negedge i_clock);
    i_instr_valid = 1'b0;
    chk(o_pc_load, 1'b1, "load");
    chk({o_taken, o_flush_next, o_delay_slot, o_illegal, o_link_we, o_break_in_progress_flag},
        r.f, "flags");
    chk(o_pc_target, r.tgt, "target");
    chk(o_ready, r.lat == 2'h1, "ready");
    if (r.f[1]) chk(o_link_sel, 5'h0f, "link sel");
    if (r.f[1]) chk(o_link_data, 32'h0000_1000, "link data");
    n = 1;
    while (o_done !== 1'b1 && n < 5) begin
      @(negedge i_clock);
      n++;
    end
    chk(n, r.lat, "latency");
  endtask : run_row

  initial begin
    rows[0]  = '{mc(0, 0, beu_pkg::COND_LT, R), 32'hffff_ffff, 32'h40, 32'h1040, 6'h30, 2'h3};
    rows[1]  = '{mc(0, 1, beu_pkg::COND_LT, R), 32'h0, 32'h40, 32'h1004, 6'h00, 2'h1};
    rows[2]  = '{mc(1, 1, beu_pkg::COND_LT, 16'hfff0), 32'h8000_0000, 32'h40, 32'h0ff0, 6'h28, 2'h2};
    rows[3]  = '{mc(1, 0, beu_pkg::COND_LT, 16'hfff0), 32'h7fff_ffff, 32'h40, 32'h1004, 6'h00, 2'h1};
    rows[4]  = '{mc(0, 0, beu_pkg::COND_NE, R), 32'h1, 32'hffff_fffc, 32'h0ffc, 6'h30, 2'h3};
    rows[5]  = '{mc(0, 1, beu_pkg::COND_NE, R), 32'h0, 32'h40, 32'h1004, 6'h00, 2'h1};
    rows[6]  = '{mc(1, 1, beu_pkg::COND_NE, 16'h0010), 32'h5, 32'h40, 32'h1010, 6'h28, 2'h2};
    rows[7]  = '{mc(1, 1, beu_pkg::COND_LE, 16'h0020), 32'h0, 32'h40, 32'h1020, 6'h28, 2'h2};
    rows[8]  = '{mc(1, 1, beu_pkg::COND_LE, 16'h0020), 32'h1, 32'h40, 32'h1004, 6'h00, 2'h1};
    rows[9]  = '{mj(0, 0, 0, 0, R), 32'h0, 32'h100, 32'h1100, 6'h30, 2'h3};
    rows[10] = '{mj(0, 1, 1, 0, R), 32'h0, 32'h2000, 32'h2000, 6'h28, 2'h2};
    rows[11] = '{mj(0, 1, 0, 1, R), 32'h0, 32'h8, 32'h1008, 6'h2a, 2'h2};
    rows[12] = '{mj(1, 0, 0, 0, 16'h8000), 32'h0, 32'h40, 32'hffff_9000, 6'h30, 2'h3};
    rows[13] = '{mj(1, 0, 1, 0, 16'h7ffc), 32'h0, 32'h40, 32'h7ffc, 6'h30, 2'h3};
    rows[14] = '{mj(1, 1, 1, 1, 16'hfffc), 32'h0, 32'h40, 32'hffff_fffc, 6'h2a, 2'h2};
    rows[15] = '{mj(0, 0, 0, 1, R), 32'h0, 32'h40, 32'h1004, 6'h04, 2'h1};
    rows[16] = '{mj(1, 0, 0, 1, 16'h0010), 32'h0, 32'h40, 32'h1004, 6'h04, 2'h1};
    rows[17] = '{mc(0, 0, 3'h0, R), 32'h0, 32'h40, 32'h1004, 6'h04, 2'h1};
    rows[18] = '{mc(0, 0, beu_pkg::COND_LE, R), 32'h0, 32'h40, 32'h1004, 6'h04, 2'h1};
    rows[19] = '{mj(0, 0, 1, 1, R), 32'h0, 32'h300, 32'h300, 6'h33, 2'h3};
    repeat (4) @(negedge i_clock);
    chk({o_ready, o_pc_load, o_done, o_break_in_progress_flag}, 4'h8, "reset state");
    chk(o_pc_target, 32'h0, "reset target");
    i_rst_n = 1'b1;
    // Break row stays last: its flag is sticky until cleared
    foreach (rows[i]) run_row(rows[i]);
    // Clear request drops the flag; a break issued with clear high still sets it
    @(negedge i_clock);
    i_break_clear = 1'b1;
    @(negedge i_clock);
    chk(o_break_in_progress_flag, 1'b0, "flag clear");
    drv(rows[19].ins, 32'h0, 32'h300, 32'h1000);
    @(negedge i_clock);
    i_instr_valid = 1'b0;
    i_break_clear = 1'b0;
    chk(o_break_in_progress_flag, 1'b1, "set wins");
    repeat (2) @(negedge i_clock);
    // Back-to-back untaken issues
    drv(rows[1].ins, 32'h0, 32'h40, 32'h1000);
    @(negedge i_clock);
    chk({o_pc_load, o_ready}, 2'h3, "b2b first");
    chk(o_pc_target, 32'h1004, "b2b first target");
    drv(rows[8].ins, 32'h1, 32'h40, 32'h2000);
    @(negedge i_clock);
    chk({o_pc_load, o_done}, 2'h3, "b2b second");
    chk(o_pc_target, 32'h2004, "b2b second target");
    // Requests while busy are ignored
    drv(rows[0].ins, 32'hffff_ffff, 32'h40, 32'h1000);
    @(negedge i_clock);
    drv(rows[10].ins, 32'h0, 32'h5000, 32'h0);
    @(negedge i_clock);
    chk(o_pc_load, 1'b0, "busy issue");
    i_instr_valid = 1'b0;
    @(negedge i_clock);
    chk({o_pc_load, o_done}, 2'h1, "busy end");
    chk(o_pc_target, 32'h1040, "busy end target");
    @(negedge i_clock);
    chk(o_pc_load, 1'b0, "busy after");
    // Reset in mid-flight returns to idle
    drv(rows[9].ins, 32'h0, 32'h100, 32'h1000);
    @(negedge i_clock);
    i_instr_valid = 1'b0;
    i_rst_n = 1'b0;
    #1;
    chk({o_ready, o_pc_load, o_break_in_progress_flag}, 3'h4, "mid reset");
    chk(o_pc_target | o_link_data, 32'h0, "mid reset data");
    @(negedge i_clock);
    i_rst_n = 1'b1;
    run_row(rows[4]);
    test_done();
  end
endmodule : tb
`default_nettype wire
